// file: inc/acr_pkg.sv
// Package: register map, field positions, reset values and types of the converter control
package acr_pkg;
	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam logic [3:0]  OFS_ANALOG   = 4'h0;
	localparam logic [3:0]  OFS_STATUS   = 4'h4;
	localparam logic [3:0]  OFS_RESULT   = 4'h8;
	localparam logic [3:0]  OFS_BIT_TIME = 4'hC;
	// --------------------------------------------------------------
	// Fields and reset values
	// --------------------------------------------------------------
	localparam int          STS_BUSY_POS  = 0;
	localparam int          STS_SHORT_POS = 1;
	localparam int          STS_PINS_POS  = 2;
	localparam logic [11:0] ANALOG_RST    = 12'h000;
	localparam logic [7:0]  BIT_TIME_RST  = 8'h04;
	localparam logic [11:0] RESULT_RST    = 12'h000;
	localparam logic [3:0]  SHORT_TAIL    = 4'h8;
	localparam logic [3:0]  MSB_IDX       = 4'hB;
	localparam logic [3:0]  STOP_FULL     = 4'h0;
	localparam logic [3:0]  STOP_SHORT    = 4'h4;
	localparam int          PIN_CNT       = 5;
	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef enum logic {ST_IDLE, ST_CONVERT} acr_state_type;
	typedef enum logic [1:0] {DRV_OFF, DRV_WORD, DRV_MSB, DRV_LSB} acr_drive_type;
endpackage

// file: design/acr_convert_read.sv
// Converter start, status and three-state read control behind an Avalon-MM slave
//
// Operation
// - A conversion starts when chip enable, select low and read-not-convert low combine.
// - The last of the three inputs to reach its start level triggers conversion.
// - All three start inputs may change together; each path has equal delay.
// - Busy output is high only while a conversion runs.
// - While busy, all data outputs are undriven and reads return nothing.
// - A start condition while busy is ignored; it neither resets nor restarts.
// - Outputs enable only with read high, idle, chip enable high, select low.
// - Active data lines follow word-width select and byte select.
// - Word width high drives all twelve lines; byte select is ignored.
// - Word width low presents two 8-bit bytes chosen by byte select.
// - Byte mode, byte select low: only the eight upper result bits drive.
// - Byte mode, byte select high: lines 7..4 low, four low bits driven.
// - Switching between bytes disables all lines before enabling the other.
// - Byte select may toggle at any time without disturbing the converter.
// - Start latches byte select: low gives 12 bits, high stops after 8.
// - After an 8-bit conversion, low result bits read 1000.
// - Chip enable low or select high: no start, no output enable.
`timescale 1ns/1ps
module acr_convert_read #(
	parameter int BIT_CYCLES = 4
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        CHIP_ENABLE,
	input  wire logic        CHIP_SELECT_N,
	input  wire logic        READ_NOT_CONVERT,
	input  wire logic        WORD_SELECT,
	input  wire logic        BYTE_SELECT,
	output logic             CONVERSION_IN_PROGRESS,
	output logic      [11:0] DATA_O,
	output logic      [11:0] DATA_OE
);
	if (BIT_CYCLES < 1 || BIT_CYCLES > 255) begin : g_chk
		$error("BIT_CYCLES must lie in 1..255");
	end

	// --------------------------------------------------------------
	// Pin synchronisers and agreement filter
	// --------------------------------------------------------------
	localparam int N = acr_pkg::PIN_CNT;
	logic [N-1:0] pins;
	logic [N-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	assign pins = {BYTE_SELECT, WORD_SELECT, READ_NOT_CONVERT, CHIP_SELECT_N, CHIP_ENABLE};

	for (genvar i = 0; i < N; i++) begin : g_filt
		always_comb begin
			filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			filt_reg <= '0;
		end else begin
			s1_reg   <= pins;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	logic ce, cs_n, rnc, word_sel, bsel;
	assign ce       = filt_reg[0];
	assign cs_n     = filt_reg[1];
	assign rnc      = filt_reg[2];
	assign word_sel = filt_reg[3];
	assign bsel     = filt_reg[4];

	// --------------------------------------------------------------
	// Avalon-MM slave, one wait state
	// --------------------------------------------------------------
	logic        ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [11:0] analog_reg, analog_next;
	logic [7:0]  bit_time_reg, bit_time_next;
	logic [11:0] result_reg, result_next;
	logic        busy;
	logic        short_reg, short_next;
	logic        req, wr_go;

	assign req             = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~ack_reg;
	assign wr_go           = AVS_WRITE & ack_reg;
	assign AVS_READDATA    = rdata_reg;

	always_comb begin
		ack_next      = req & ~ack_reg;
		rdata_next    = rdata_reg;
		analog_next   = analog_reg;
		bit_time_next = bit_time_reg;
		if (AVS_READ && !ack_reg) begin
			if (AVS_ADDRESS == acr_pkg::OFS_ANALOG) begin
				rdata_next = {20'h0_0000, analog_reg};
			end else if (AVS_ADDRESS == acr_pkg::OFS_STATUS) begin
				rdata_next = '0;
				rdata_next[acr_pkg::STS_BUSY_POS]  = busy;
				rdata_next[acr_pkg::STS_SHORT_POS] = short_reg;
				rdata_next[acr_pkg::STS_PINS_POS +: N] = filt_reg;
			end else if (AVS_ADDRESS == acr_pkg::OFS_RESULT) begin
				rdata_next = {20'h0_0000, result_reg};
			end else if (AVS_ADDRESS == acr_pkg::OFS_BIT_TIME) begin
				rdata_next = {24'h00_0000, bit_time_reg};
			end else begin
				rdata_next = 32'h0000_0000;
			end
		end
		if (wr_go) begin
			if (AVS_ADDRESS == acr_pkg::OFS_ANALOG) begin
				if (AVS_BYTEENABLE[0]) analog_next[7:0] = AVS_WRITEDATA[7:0];
				if (AVS_BYTEENABLE[1]) analog_next[11:8] = AVS_WRITEDATA[11:8];
			end else if (AVS_ADDRESS == acr_pkg::OFS_BIT_TIME) begin
				if (AVS_BYTEENABLE[0]) bit_time_next = AVS_WRITEDATA[7:0];
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ack_reg      <= 1'b0;
			rdata_reg    <= 32'h0000_0000;
			analog_reg   <= acr_pkg::ANALOG_RST;
			bit_time_reg <= 8'(BIT_CYCLES);
		end else begin
			ack_reg      <= ack_next;
			rdata_reg    <= rdata_next;
			analog_reg   <= analog_next;
			bit_time_reg <= bit_time_next;
		end
	end

	// --------------------------------------------------------------
	// Start detection and successive approximation
	// --------------------------------------------------------------
	acr_pkg::acr_state_type state_reg, state_next;
	logic        start_cond, prev_reg, start_rise;
	logic [3:0]  idx_reg, idx_next;
	logic [7:0]  timer_reg, timer_next, bt_eff;
	logic [11:0] sar_reg, sar_next, trial;
	logic [3:0]  stop_idx;

	assign start_cond = ce & ~cs_n & ~rnc;
	assign start_rise = start_cond & ~prev_reg;
	assign busy       = (state_reg == acr_pkg::ST_CONVERT);
	assign bt_eff     = (bit_time_reg == 8'h00) ? 8'h01 : bit_time_reg;
	assign trial      = sar_reg | (12'h001 << idx_reg);
	assign stop_idx   = short_reg ? acr_pkg::STOP_SHORT : acr_pkg::STOP_FULL;

	always_comb begin
		state_next  = state_reg;
		idx_next    = idx_reg;
		timer_next  = timer_reg;
		sar_next    = sar_reg;
		short_next  = short_reg;
		result_next = result_reg;
		case (state_reg)
			acr_pkg::ST_IDLE: begin
				if (start_rise) begin
					state_next = acr_pkg::ST_CONVERT;
					idx_next   = acr_pkg::MSB_IDX;
					timer_next = bt_eff;
					sar_next   = '0;
					short_next = bsel;
				end
			end
			acr_pkg::ST_CONVERT: begin
				// Further starts are not looked at here
				if (timer_reg > 8'h01) begin
					timer_next = timer_reg - 8'h01;
				end else begin
					if (trial <= analog_reg) begin
						sar_next = trial;
					end
					if (idx_reg == stop_idx) begin
						state_next  = acr_pkg::ST_IDLE;
						result_next = (trial <= analog_reg) ? trial : sar_reg;
						if (short_reg) begin
							result_next[3:0] = acr_pkg::SHORT_TAIL;
						end
					end else begin
						idx_next   = idx_reg - 4'h1;
						timer_next = bt_eff;
					end
				end
			end
			default: state_next = acr_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_reg  <= acr_pkg::ST_IDLE;
			prev_reg   <= 1'b0;
			idx_reg    <= 4'h0;
			timer_reg  <= 8'h00;
			sar_reg    <= 12'h000;
			short_reg  <= 1'b0;
			result_reg <= acr_pkg::RESULT_RST;
		end else begin
			state_reg  <= state_next;
			prev_reg   <= start_cond;
			idx_reg    <= idx_next;
			timer_reg  <= timer_next;
			sar_reg    <= sar_next;
			short_reg  <= short_next;
			result_reg <= result_next;
		end
	end

	assign CONVERSION_IN_PROGRESS = busy;

	// --------------------------------------------------------------
	// Output drive with break-before-make
	// --------------------------------------------------------------
	acr_pkg::acr_drive_type drv_reg, drv_next, want;
	logic        out_en;
	logic [11:0] data_reg, data_next, oe_reg, oe_next;

	// Byte select is only a mux steer here, never a reset
	assign out_en = rnc & ~busy & ce & ~cs_n;

	always_comb begin
		if (!out_en) begin
			want = acr_pkg::DRV_OFF;
		end else if (word_sel) begin
			want = acr_pkg::DRV_WORD;
		end else if (!bsel) begin
			want = acr_pkg::DRV_MSB;
		end else begin
			want = acr_pkg::DRV_LSB;
		end
		// A change between two driven modes passes through all-off
		if (drv_reg == want || drv_reg == acr_pkg::DRV_OFF || want == acr_pkg::DRV_OFF) begin
			drv_next = want;
		end else begin
			drv_next = acr_pkg::DRV_OFF;
		end
		case (drv_next)
			acr_pkg::DRV_WORD: begin
				oe_next   = 12'hFFF;
				data_next = result_reg;
			end
			acr_pkg::DRV_MSB: begin
				oe_next   = 12'hFF0;
				data_next = {result_reg[11:4], 4'h0};
			end
			acr_pkg::DRV_LSB: begin
				oe_next   = 12'h0FF;
				data_next = {4'h0, 4'h0, result_reg[3:0]};
			end
			default: begin
				oe_next   = 12'h000;
				data_next = 12'h000;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			drv_reg  <= acr_pkg::DRV_OFF;
			data_reg <= 12'h000;
			oe_reg   <= 12'h000;
		end else begin
			drv_reg  <= drv_next;
			data_reg <= data_next;
			oe_reg   <= oe_next;
		end
	end

	assign DATA_O  = data_reg;
	assign DATA_OE = oe_reg;

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	AST_START_ACCEPT: assert property (
		start_rise && !busy |=> busy && $rose(CONVERSION_IN_PROGRESS))
		else $error("Start condition not accepted");
	AST_LAST_INPUT: assert property (
		$rose(start_cond) && $past(ce) && $past(!cs_n) |-> $fell(rnc))
		else $error("Start rise without a triggering input");
	AST_START_IGNORED: assert property (
		busy && start_rise |=> busy && short_reg == $past(short_reg))
		else $error("Start while busy disturbed the conversion");
	AST_HIZ_BUSY: assert property (busy |-> ##1 DATA_OE == 12'h000)
		else $error("Outputs driven during conversion");
	AST_OE_QUAL: assert property (DATA_OE != 12'h000 |-> $past(rnc && ce && !cs_n && !busy))
		else $error("Outputs enabled without full read qualification");
	AST_WORD_ALL: assert property (
		DATA_OE == 12'hFFF |-> $past(word_sel) && DATA_O == $past(result_reg))
		else $error("Word read wrong");
	AST_MSB_BYTE: assert property (
		DATA_OE == 12'hFF0 |-> DATA_O[11:4] == $past(result_reg[11:4]))
		else $error("Upper byte wrong");
	AST_LSB_BYTE: assert property (
		DATA_OE == 12'h0FF |-> DATA_O[7:4] == 4'h0 && DATA_O[3:0] == $past(result_reg[3:0]))
		else $error("Lower byte wrong");
	AST_BBM: assert property (
		DATA_OE != 12'h000 && $changed(DATA_OE) |-> $past(DATA_OE) == 12'h000)
		else $error("Byte switch without a gap");
	AST_SHORT_TAIL: assert property (
		$fell(busy) && short_reg |-> result_reg[3:0] == acr_pkg::SHORT_TAIL)
		else $error("Short conversion tail wrong");
	AST_BUSY_END: assert property (
		$fell(busy) |-> $past(idx_reg) == $past(stop_idx) && $past(timer_reg) <= 8'h01)
		else $error("Busy fell before the last decision");

	COV_FULL: cover property ($fell(busy) && !short_reg);
	COV_SHORT: cover property ($fell(busy) && short_reg);
	COV_BYTE_SWAP: cover property (DATA_OE == 12'hFF0 ##1 DATA_OE == 12'h000 ##1 DATA_OE == 12'h0FF);
	COV_IGNORED: cover property (busy && start_rise);
endmodule // acr_convert_read

// file: tb/acr_host_model.sv
// Host model: drives the converter control pins and views the three-state data bus
`timescale 1ns/1ps
module acr_host_model (
	input  wire logic        clk,
	input  wire logic [11:0] data_o,
	input  wire logic [11:0] data_oe,
	output logic      [4:0]  pins,
	output logic      [11:0] data_bus
);
	logic [11:0] hold_reg = 12'h000;
	// --------------------------------------------------------------
	// Bus view: an undriven line shows the inverse of its last level
	// --------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			data_bus[i] = data_oe[i] ? data_o[i] : ~hold_reg[i];
		end
	end
	always_ff @(posedge clk) begin
		hold_reg <= data_bus;
	end
	initial begin
		pins = 5'b01110;
	end
	// --------------------------------------------------------------
	// Pins {byte select, word, read, select low, enable}
	// --------------------------------------------------------------
	task automatic drive(input logic [4:0] v);
		@(posedge clk);
		pins <= v;
	endtask
endmodule // acr_host_model

// file: tb/tb_adc_convert_read_control.sv
// Testbench: start, status and three-state read behaviour of the converter control
`timescale 1ns/1ps
module tb_adc_convert_read_control;
	localparam int BITS = 1;
	logic        clk_sys    = 1'b0;
	logic        rst_n      = 1'b0;
	logic [3:0]  addr       = 4'h0;
	logic        rd         = 1'b0;
	logic        wr         = 1'b0;
	logic [31:0] wdata      = 32'h0000_0000;
	logic [3:0]  ben        = 4'hF;
	logic [3:0]  ben_sel    = 4'hF;
	logic [31:0] rdata;
	logic        wait_req;
	logic        busy;
	logic [11:0] dout;
	logic [11:0] doe;
	logic [11:0] oe_prev    = 12'h000;
	logic [4:0]  pins;
	logic [11:0] data_bus;
	int          error_cnt  = 0;
	int          comparisons = 0;

	always #12.5 clk_sys = ~clk_sys;

	acr_convert_read #(.BIT_CYCLES(BITS)) dut (
		.CLK_SYS(clk_sys), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(ben),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .CHIP_ENABLE(pins[0]),
		.CHIP_SELECT_N(pins[1]), .READ_NOT_CONVERT(pins[2]), .WORD_SELECT(pins[3]),
		.BYTE_SELECT(pins[4]), .CONVERSION_IN_PROGRESS(busy), .DATA_O(dout), .DATA_OE(doe)
	);
	acr_host_model host (.clk(clk_sys), .data_o(dout), .data_oe(doe), .pins(pins),
		.data_bus(data_bus));

	// --------------------------------------------------------------
	// Checks and bus tasks
	// --------------------------------------------------------------
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic test_done;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		addr <= a;
		ben <= ben_sel;
		wr <= w;
		rd <= ~w;
		wdata <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wait_req !== 1'b0 && n < 50);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		cmp("bus_answer", 32'h1, 32'(n < 50));
	endtask
	// Length of the busy pulse in cycles
	task automatic conv(input int len);
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		n = 0;
		while (busy === 1'b1 && n < 999) begin
			@(negedge clk_sys);
			n++;
		end
		cmp("busy_len", len, n);
	endtask
	// Pins pass the filter, a possible all-off cycle and the output register
	task automatic chk_out(input logic [11:0] e_oe, input logic [11:0] e_dat);
		repeat (8) @(negedge clk_sys);
		cmp("data_oe", e_oe, doe);
		cmp("data_bus", e_dat, data_bus & doe);
	endtask

	always @(negedge clk_sys) begin
		if (rst_n) begin
			if (busy === 1'b1) cmp("oe_busy", 0, doe);
			if (oe_prev !== 12'h000 && doe !== 12'h000) cmp("oe_switch", oe_prev, doe);
			oe_prev <= doe;
		end
	end

	initial begin
		#(25 * 20000);
		error_cnt++;
		test_done();
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin : main
		logic [31:0] q;
		logic [3:0]  ra [5] = '{acr_pkg::OFS_ANALOG, acr_pkg::OFS_STATUS, acr_pkg::OFS_RESULT,
			acr_pkg::OFS_BIT_TIME, 4'h2};
		logic [31:0] re [5] = '{32'h0, 32'h38, 32'h0, BITS, 32'h0};
		logic [4:0]  none [3] = '{5'b01000, 5'b01100, 5'b01011};
		logic [4:0]  mode [4] = '{5'b01101, 5'b00101, 5'b10101, 5'b11101};
		logic [11:0] m_oe [4] = '{12'hFFF, 12'hFF0, 12'h0FF, 12'hFFF};
		logic [11:0] m_dt [4] = '{12'hA5C, 12'hA50, 12'h00C, 12'hA5C};
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		bus(1'b1, acr_pkg::OFS_RESULT, 32'h0000_0123, q);
		bus(1'b1, 4'h2, 32'h0000_0FFF, q);
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 32'h0000_0000, q);
			cmp("reg_read", re[i], q);
		end
		ben_sel = 4'h2;
		bus(1'b1, acr_pkg::OFS_ANALOG, 32'h0000_0FFF, q);
		bus(1'b1, acr_pkg::OFS_BIT_TIME, 32'h0000_00FF, q);
		ben_sel = 4'hF;
		bus(1'b0, acr_pkg::OFS_ANALOG, 32'h0000_0000, q);
		cmp("analog_lane", 32'h0000_0F00, q);
		bus(1'b0, acr_pkg::OFS_BIT_TIME, 32'h0000_0000, q);
		cmp("bit_time_lane", BITS, q);
		bus(1'b1, acr_pkg::OFS_ANALOG, 32'h0000_0A5C, q);
		bus(1'b1, acr_pkg::OFS_BIT_TIME, 32'h0000_0004, q);
		foreach (none[i]) begin
			host.drive(none[i]);
			repeat (8) @(negedge clk_sys);
			cmp("busy_idle", 0, busy);
			cmp("oe_idle", 0, doe);
		end
		host.drive(5'b01101);
		repeat (2) @(posedge clk_sys);
		host.drive(5'b01001);
		fork
			conv(48);
			begin
				repeat (12) @(posedge clk_sys);
				host.drive(5'b01101);
				repeat (8) @(posedge clk_sys);
				host.drive(5'b01001);
				repeat (6) @(posedge clk_sys);
				host.drive(5'b01101);
			end
		join
		foreach (mode[i]) begin
			host.drive(mode[i]);
			chk_out(m_oe[i], m_dt[i]);
		end
		bus(1'b1, acr_pkg::OFS_BIT_TIME, 32'h0000_0001, q);
		host.drive(5'b11000);
		repeat (2) @(posedge clk_sys);
		host.drive(5'b11001);
		conv(8);
		host.drive(5'b11101);
		chk_out(12'hFFF, 12'hA58);
		host.drive(5'b01110);
		repeat (2) @(posedge clk_sys);
		host.drive(5'b01001);
		conv(12);
		host.drive(5'b01101);
		chk_out(12'hFFF, 12'hA5C);
		bus(1'b0, acr_pkg::OFS_RESULT, 32'h0000_0000, q);
		cmp("result", 32'h0000_0A5C, q);
		test_done();
	end
endmodule // tb_adc_convert_read_control
